//--- design/tpu_cfg.svh
// Offsets, field positions, reset values and timing counts of the timer based PWM unit
`ifndef TPU_CFG_SVH
`define TPU_CFG_SVH

// Word indices on the Avalon-MM bus; the byte address is four times the index
`define TPU_IDX_COUNT 4'h0
`define TPU_IDX_LIMIT 4'h1
`define TPU_IDX_TCTRL 4'h2
`define TPU_IDX_U1_UPPER 4'h3
`define TPU_IDX_U1_SHADOW 4'h4
`define TPU_IDX_U1_CTRL 4'h5
`define TPU_IDX_U2_UPPER 4'h6
`define TPU_IDX_U2_SHADOW 4'h7
`define TPU_IDX_U2_CTRL 4'h8
`define TPU_IDX_STEER 4'h9
`define TPU_IDX_FLAGS 4'ha
`define TPU_IDX_DIR 4'hb

// Field positions of the timer control register
`define TPU_TC_PS_LSB 0
`define TPU_TC_RUN 2
`define TPU_TC_POST_LSB 3

// Field positions of a unit control register
`define TPU_UC_DLOW_LSB 4
`define TPU_UC_MODE_PWM 4'hc

// Reset values
`define TPU_RST_COUNT 8'h00
`define TPU_RST_LIMIT 8'hff
`define TPU_RST_TCTRL 7'h00
`define TPU_RST_BYTE 8'h00
`define TPU_RST_STEER 4'h1
`define TPU_RST_DIR 5'h1f

// Timing counts: oscillator clocks per tick, last divider value, last prescale counter values in ticks
`define TPU_OSC_PER_TICK 4
`define TPU_Q_LAST 2'h3
`define TPU_PS4_LAST 2'h3
`define TPU_PS16_LAST 4'hf

`endif

//--- design/tpu_pkg.sv
// Types of the timer based PWM unit
package tpu_pkg;
	// Prescale selection decoded from the two select bits
	typedef enum logic [1:0] {
		TPU_PS_1,
		TPU_PS_4,
		TPU_PS_16
	} tpu_ps_t;

	typedef logic [9:0] tpu_duty_t;
	typedef logic [7:0] tpu_byte_t;

	// Decode of the prescale select field: 00 = 1, 01 = 4, 1x = 16
	function automatic tpu_ps_t tpu_ps_decode(input logic [1:0] sel);
		tpu_ps_t ps;
		ps = TPU_PS_16;
		if (sel == 2'h0) begin
			ps = TPU_PS_1;
		end else if (sel == 2'h1) begin
			ps = TPU_PS_4;
		end
		return ps;
	endfunction
endpackage

//--- design/tpu_top.sv
// Timer based PWM unit: shared period timer, two pulse-width units, Avalon-MM register slave
//
// Function
// [RL1] Period is (limit+1) x 4 x prescale clocks
// [RL2] Timer clears on increment after limit match
// [RL3] Pin set each period unless duty zero
// [RL4] Match copies duty into shadow and latch
// [RL5] Postscaler never affects PWM period
// [RL6] Duty is upper byte plus two low bits
// [RL7] Duty writes apply only at period end
// [RL8] Shadow register read-only in pulse-width mode
// [RL9] Shadow plus 2-bit latch double buffer duty
// [RL10] Time base: timer plus divider/prescaler bits
// [RL11] Time base equals duty clears the pin
// [RL12] High time is duty x prescaled clocks
// [RL13] Resolution grows with period limit value
// [RL14] Duty beyond period: no falling edge
// [RL15] Sleep freezes all state and pin levels
// [RL16] Primary idle keeps primary clock running
// [RL17] Reset restores registers, pins to input
// [RL18] Software set-up order ends enabling pin
// [RL19] Prescale 1, 4, 16 with run bit
// [RL20] Steering bits route unit 1 outputs
// [RL21] Direction bit cleared before pin drives
// [RL22] Zero unit control releases the pin
// [RL23] Clear, set and load on one edge
// [RL24] Match sets the timer match flag
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "tpu_cfg.svh"

module tpu_top
	import tpu_pkg::*;
(
	// Clock, reset and clock enable (low = sleep)
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Unit 1 steered outputs a to d
	output logic [3:0] u1_pin_o,
	output logic [3:0] u1_pin_oe_o,
	// Unit 2 output pin
	output logic u2_pin_o,
	output logic u2_pin_oe_o,
	// Timer match flag
	output logic match_flag_o
);
	// Register state
	tpu_byte_t count_r;
	tpu_byte_t limit_r;
	logic [6:0] tctrl_r;
	tpu_byte_t upper_r [2];
	tpu_byte_t shadow_r [2];
	logic [1:0] latch_r [2];
	tpu_byte_t uctrl_r [2];
	logic [3:0] steer_r;
	logic [4:0] dir_r;
	logic flag_r;
	logic [1:0] q_r;
	logic [3:0] pre_r;
	logic [1:0] pwm_r;
	logic waitreq_r;
	logic [31:0] rdata_r;
	logic [3:0] u1_pin_r;
	logic [3:0] u1_oe_r;
	logic u2_pin_r;
	logic u2_oe_r;

	// Decoded strobes and timing terms
	logic acc_go;
	logic wr_go;
	logic [7:0] wbyte;
	tpu_ps_t ps;
	logic run;
	logic tick;
	logic inc;
	logic match;
	logic [1:0] tb_low;
	logic tb_step;
	tpu_duty_t timebase;
	tpu_duty_t tb_next;
	tpu_duty_t duty_act [2];
	logic [1:0] pwm_mode;
	logic [1:0] ctrl_on;
	logic [1:0] cmp_hit;

	// An access completes on the second cycle, when waitrequest is low
	assign acc_go = ce_i && (avs_read_i || avs_write_i) && !waitreq_r;
	assign wr_go = acc_go && avs_write_i && avs_byteenable_i[0];
	assign wbyte = avs_writedata_i[7:0];

	// Prescaler; the postscale field is stored but feeds nothing here
	assign ps = tpu_ps_decode(tctrl_r[`TPU_TC_PS_LSB +: 2]); // RL19 RL5
	assign run = tctrl_r[`TPU_TC_RUN]; // RL19
	assign tick = run && (q_r == `TPU_Q_LAST);
	always_comb begin
		inc = tick;
		tb_low = q_r; // RL10
		tb_step = run;
		case (ps)
			TPU_PS_1: begin
				inc = tick;
				tb_low = q_r;
				tb_step = run;
			end
			TPU_PS_4: begin
				inc = tick && (pre_r[1:0] == `TPU_PS4_LAST);
				tb_low = pre_r[1:0];
				tb_step = tick;
			end
			TPU_PS_16: begin
				inc = tick && (pre_r == `TPU_PS16_LAST);
				tb_low = pre_r[3:2];
				tb_step = tick && (pre_r[1:0] == `TPU_PS4_LAST);
			end
			default: begin
				inc = 1'b0;
				tb_low = 2'h0;
				tb_step = 1'b0;
			end
		endcase
	end
	assign match = inc && (count_r == limit_r); // RL2 RL1
	assign timebase = {count_r, tb_low}; // RL10 RL13
	// The pin falls on the edge where the time base steps onto the duty, so high time is exactly duty time-base steps
	assign tb_next = timebase + 10'h001; // RL12

	// Per-unit decode of mode, active duty and compare
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			pwm_mode[u] = (uctrl_r[u][3:2] == `TPU_UC_MODE_PWM >> 2);
			ctrl_on[u] = (uctrl_r[u] != 8'h00);
			duty_act[u] = {shadow_r[u], latch_r[u]}; // RL9
			cmp_hit[u] = tb_step && (tb_next == duty_act[u]); // RL11 RL14
		end
	end

	// Oscillator divider and prescale counter, cleared by a count write
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q_r <= 2'h0;
			pre_r <= 4'h0;
		end else if (ce_i) begin // RL15 RL16
			if (wr_go && avs_address_i == `TPU_IDX_COUNT) begin
				q_r <= 2'h0;
				pre_r <= 4'h0;
			end else if (run) begin
				q_r <= q_r + 2'h1;
				if (tick) begin
					pre_r <= pre_r + 4'h1;
				end
			end
		end
	end

	// Period timer, limit and timer control
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_r <= `TPU_RST_COUNT; // RL17
			limit_r <= `TPU_RST_LIMIT;
			tctrl_r <= `TPU_RST_TCTRL;
		end else if (ce_i) begin
			if (wr_go && avs_address_i == `TPU_IDX_COUNT) begin
				count_r <= wbyte;
			end else if (match) begin
				count_r <= 8'h00; // RL2 RL23
			end else if (inc) begin
				count_r <= count_r + 8'h01;
			end
			if (wr_go && avs_address_i == `TPU_IDX_LIMIT) begin
				limit_r <= wbyte;
			end
			if (wr_go && avs_address_i == `TPU_IDX_TCTRL) begin
				tctrl_r <= wbyte[6:0];
			end
		end
	end

	// Duty registers, shadow load at the period match and unit control
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int u = 0; u < 2; u++) begin
				upper_r[u] <= `TPU_RST_BYTE;
				shadow_r[u] <= `TPU_RST_BYTE;
				latch_r[u] <= 2'h0;
				uctrl_r[u] <= `TPU_RST_BYTE;
			end
		end else if (ce_i) begin
			for (int u = 0; u < 2; u++) begin
				// Upper byte and low bits may be written at any time
				if (wr_go && avs_address_i == `TPU_IDX_U1_UPPER + 4'(3 * u)) begin
					upper_r[u] <= wbyte; // RL6 RL7
				end
				if (wr_go && avs_address_i == `TPU_IDX_U1_CTRL + 4'(3 * u)) begin
					uctrl_r[u] <= (u == 1) ? {2'h0, wbyte[5:0]} : wbyte;
				end
				if (pwm_mode[u] && match) begin
					shadow_r[u] <= upper_r[u]; // RL4 RL7 RL23
					latch_r[u] <= uctrl_r[u][`TPU_UC_DLOW_LSB +: 2]; // RL6 RL9
				end else if (!pwm_mode[u] && wr_go && avs_address_i == `TPU_IDX_U1_SHADOW + 4'(3 * u)) begin
					shadow_r[u] <= wbyte; // RL8
				end
			end
		end
	end

	// Waveform: set at the period match, cleared when the time base meets the duty
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwm_r <= 2'h0;
		end else if (ce_i) begin
			for (int u = 0; u < 2; u++) begin
				if (!pwm_mode[u]) begin
					pwm_r[u] <= 1'b0;
				end else if (match) begin
					// The new duty is the one being latched on this same edge
					pwm_r[u] <= ({upper_r[u], uctrl_r[u][`TPU_UC_DLOW_LSB +: 2]} != 10'h000); // RL3 RL23
				end else if (cmp_hit[u]) begin
					pwm_r[u] <= 1'b0; // RL11 RL12 RL14
				end
			end
		end
	end

	// Steering, pin direction and the match flag (set wins over clear)
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			steer_r <= `TPU_RST_STEER;
			dir_r <= `TPU_RST_DIR; // RL17
			flag_r <= 1'b0;
		end else if (ce_i) begin
			if (wr_go && avs_address_i == `TPU_IDX_STEER) begin
				steer_r <= wbyte[3:0]; // RL20
			end
			if (wr_go && avs_address_i == `TPU_IDX_DIR) begin
				dir_r <= wbyte[4:0]; // RL21
			end
			if (match) begin
				flag_r <= 1'b1; // RL24
			end else if (wr_go && avs_address_i == `TPU_IDX_FLAGS && wbyte[0]) begin
				flag_r <= 1'b0;
			end
		end
	end

	// Registered pin drivers: enables set only when the unit control is nonzero, the unit owns the pin and the direction is output
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			u1_pin_r <= 4'h0;
			u1_oe_r <= 4'h0; // RL17
			u2_pin_r <= 1'b0;
			u2_oe_r <= 1'b0;
		end else if (ce_i) begin
			u1_pin_r <= {4{pwm_r[0]}} & steer_r; // RL20
			u1_oe_r <= {4{ctrl_on[0]}} & steer_r & ~dir_r[3:0]; // RL20 RL21 RL22
			u2_pin_r <= pwm_r[1];
			u2_oe_r <= ctrl_on[1] && !dir_r[4]; // RL21 RL22
		end
	end

	// Bus handshake: waitrequest drops for one cycle, read data captured just before
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			waitreq_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if (ce_i) begin
			waitreq_r <= !((avs_read_i || avs_write_i) && waitreq_r);
			if (avs_read_i && waitreq_r) begin
				case (avs_address_i)
					`TPU_IDX_COUNT: rdata_r <= {24'h0, count_r};
					`TPU_IDX_LIMIT: rdata_r <= {24'h0, limit_r};
					`TPU_IDX_TCTRL: rdata_r <= {25'h0, tctrl_r};
					`TPU_IDX_U1_UPPER: rdata_r <= {24'h0, upper_r[0]};
					`TPU_IDX_U1_SHADOW: rdata_r <= {24'h0, shadow_r[0]};
					`TPU_IDX_U1_CTRL: rdata_r <= {24'h0, uctrl_r[0]};
					`TPU_IDX_U2_UPPER: rdata_r <= {24'h0, upper_r[1]};
					`TPU_IDX_U2_SHADOW: rdata_r <= {24'h0, shadow_r[1]};
					`TPU_IDX_U2_CTRL: rdata_r <= {24'h0, uctrl_r[1]};
					`TPU_IDX_STEER: rdata_r <= {28'h0, steer_r};
					`TPU_IDX_FLAGS: rdata_r <= {31'h0, flag_r};
					`TPU_IDX_DIR: rdata_r <= {27'h0, dir_r};
					default: rdata_r <= 32'h0000_0000; // Unmapped reads as zero
				endcase
			end
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = waitreq_r;
	assign u1_pin_o = u1_pin_r;
	assign u1_pin_oe_o = u1_oe_r;
	assign u2_pin_o = u2_pin_r;
	assign u2_pin_oe_o = u2_oe_r;
	assign match_flag_o = flag_r;

	// Assertions
	sequence s_match;
		ce_i && match;
	endsequence

	sequence s_new_period;
		count_r == 8'h00 && flag_r;
	endsequence

	property p_clear;
		@(posedge clock_i) disable iff (!nrst_i)
		s_match and !(wr_go && avs_address_i == `TPU_IDX_COUNT) |=> s_new_period;
	endproperty
	a_clear: assert property (p_clear) else $error("timer not cleared at period match"); // RL2

	property p_load;
		@(posedge clock_i) disable iff (!nrst_i)
		s_match and pwm_mode[0] |=> shadow_r[0] == $past(upper_r[0]) && latch_r[0] == $past(uctrl_r[0][5:4]);
	endproperty
	a_load: assert property (p_load) else $error("shadow duty not loaded at match"); // RL4

	property p_set;
		@(posedge clock_i) disable iff (!nrst_i)
		s_match and (pwm_mode[0] && {upper_r[0], uctrl_r[0][5:4]} != 10'h000)
			|=> pwm_r[0] ##1 (u1_pin_r[0] == $past(steer_r[0]) || !$past(ce_i));
	endproperty
	a_set: assert property (p_set) else $error("pin not set at new period"); // RL3

	property p_zero;
		@(posedge clock_i) disable iff (!nrst_i)
		s_match and ({upper_r[1], uctrl_r[1][5:4]} == 10'h000) |=> !pwm_r[1];
	endproperty
	a_zero: assert property (p_zero) else $error("pin set with zero duty"); // RL3

	property p_fall;
		@(posedge clock_i) disable iff (!nrst_i)
		ce_i && pwm_mode[0] && !match && cmp_hit[0] |=> !pwm_r[0];
	endproperty
	a_fall: assert property (p_fall) else $error("pin not cleared at duty match"); // RL11

	// In pulse-width mode a high pin only falls on a duty compare or a zero-duty period start
	property p_hold;
		@(posedge clock_i) disable iff (!nrst_i)
		ce_i && pwm_mode[0] && pwm_r[0] && !match && !cmp_hit[0] |=> pwm_r[0];
	endproperty
	a_hold: assert property (p_hold) else $error("pin fell without duty compare"); // RL14

	property p_ro_shadow;
		@(posedge clock_i) disable iff (!nrst_i)
		pwm_mode[0] && $stable(pwm_mode[0]) && !match |=> $stable(shadow_r[0]);
	endproperty
	a_ro_shadow: assert property (p_ro_shadow) else $error("shadow changed outside match"); // RL8

	property p_stop;
		@(posedge clock_i) disable iff (!nrst_i)
		!run && !(wr_go && avs_address_i == `TPU_IDX_COUNT) |=> $stable(count_r);
	endproperty
	a_stop: assert property (p_stop) else $error("timer counts while stopped"); // RL19

	property p_sleep;
		@(posedge clock_i) disable iff (!nrst_i)
		!ce_i |=> $stable(count_r) && $stable(pwm_r) && $stable(u1_pin_r) && $stable(waitreq_r);
	endproperty
	a_sleep: assert property (p_sleep) else $error("state moved while clock enable low"); // RL15

	property p_release;
		@(posedge clock_i) disable iff (!nrst_i)
		ce_i && uctrl_r[1] == 8'h00 |=> !u2_oe_r;
	endproperty
	a_release: assert property (p_release) else $error("pin not released with zero control"); // RL22

	property p_steer;
		@(posedge clock_i) disable iff (!nrst_i)
		(u1_oe_r & ~$past(steer_r)) == 4'h0 || !$past(ce_i);
	endproperty
	a_steer: assert property (p_steer) else $error("unsteered output driven"); // RL20
endmodule

//--- test/tpu_load.sv
// External load on steered output a: pull-down plus pulse timing meter
`timescale 1ns/1ns
module tpu_load (
	// Clock
	input wire logic clock_i,
	// Pin driver and its enable
	input wire logic pin_i,
	input wire logic oe_i,
	// Line level and last high time and period in clocks
	output logic lvl_o,
	output int hi_len_o,
	output int per_len_o
);
	int hcnt = 0;
	int pcnt = 0;
	logic prev = 1'b0;
	// Pull-down holds the line low until the driver is enabled
	assign lvl_o = oe_i ? pin_i : 1'b0;
	// Clocks between rising edges and clocks spent high
	always @(posedge clock_i) begin
		prev <= lvl_o;
		pcnt <= pcnt + 1;
		if (lvl_o && !prev) begin
			per_len_o <= pcnt;
			pcnt <= 1;
			hcnt <= 1;
		end else if (lvl_o) begin
			hcnt <= hcnt + 1;
		end
		if (!lvl_o && prev) begin
			hi_len_o <= hcnt;
		end
	end
endmodule

//--- test/tpu_top_tb.sv
// Self-checking bench of the timer based PWM unit
`timescale 1ns/1ns
`include "tpu_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("Error at %0t: got %h, expected %h", $time, g, e); end end
module tpu_top_tb
	import tpu_pkg::*;
;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] u1_pin;
	logic [3:0] u1_oe;
	logic u2_pin;
	logic u2_oe;
	logic flag;
	logic lvl;
	logic [3:0] p;
	int hi_len;
	int per_len;
	int mismatches = 0;
	int n_tests = 0;
	int cnt;
	int f;
	tpu_byte_t d;
	// Design and load on output a
	tpu_top i_tpu_top (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .avs_address_i(avs_address),
		.avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.u1_pin_o(u1_pin), .u1_pin_oe_o(u1_oe), .u2_pin_o(u2_pin), .u2_pin_oe_o(u2_oe), .match_flag_o(flag));
	tpu_load i_tpu_load (.clock_i(clock_i), .pin_i(u1_pin[0]), .oe_i(u1_oe[0]), .lvl_o(lvl),
		.hi_len_o(hi_len), .per_len_o(per_len));
	// 125 MHz clock
	initial begin
		forever #4 clock_i = ~clock_i;
	end
	// Bus write, held until waitrequest is seen low
	task automatic wr(input logic [3:0] a, input tpu_byte_t v);
		@(posedge clock_i);
		avs_address <= a;
		avs_writedata <= {24'h000000, v};
		avs_write <= 1'b1;
		do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	// Bus read, data taken at the edge that ends the wait
	task automatic rd(input logic [3:0] a, output tpu_byte_t v);
		@(posedge clock_i);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
		v = avs_readdata[7:0];
		avs_read <= 1'b0;
	endtask
	// Clear the match flag and poll until the next period starts
	task automatic wait_flag;
		wr(`TPU_IDX_FLAGS, 8'h01);
		cnt = 0;
		do begin rd(`TPU_IDX_FLAGS, d); cnt++; end while (d[0] !== 1'b1 && cnt < 200);
		`CHK(d[0], 1'b1)
	endtask
	// Count clocks with the line high in a window
	task automatic hi_in(input int n, output int h);
		h = 0;
		repeat (n) begin @(posedge clock_i); if (lvl === 1'b1) h++; end
	endtask
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (30000) @(posedge clock_i);
		mismatches++;
		end_sim();
	end
	// Test sequence
	initial begin
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b1;
		rd(`TPU_IDX_LIMIT, d); `CHK(d, `TPU_RST_LIMIT)
		rd(`TPU_IDX_DIR, d); `CHK(d, {3'h0, `TPU_RST_DIR})
		rd(`TPU_IDX_STEER, d); `CHK(d, {4'h0, `TPU_RST_STEER})
		rd(`TPU_IDX_U1_CTRL, d); `CHK(d, `TPU_RST_BYTE)
		rd(4'hc, d); `CHK(d, 8'h00)
		`CHK(u1_oe, 4'h0)
		// Set-up: limit 3, duty {01,10} = 6, prescale 1:1, then enable the pin
		wr(`TPU_IDX_LIMIT, 8'h03);
		wr(`TPU_IDX_U1_CTRL, 8'h2c);
		wr(`TPU_IDX_U1_UPPER, 8'h01);
		wr(`TPU_IDX_TCTRL, 8'h04);
		wait_flag();
		`CHK(flag, 1'b1)
		wr(`TPU_IDX_DIR, 8'h0e);
		repeat (2) @(posedge clock_i);
		`CHK(u1_oe, 4'h1)
		`CHK(u2_oe, 1'b0)
		rd(`TPU_IDX_U1_SHADOW, d); `CHK(d, 8'h01)
		wr(`TPU_IDX_U1_SHADOW, 8'h55);
		rd(`TPU_IDX_U1_SHADOW, d); `CHK(d, 8'h01)
		// Every prescale select: period 16 x factor, high 6 x factor
		for (int s = 0; s < 4; s++) begin
			f = (s == 0) ? 1 : (s == 1) ? 4 : 16;
			wr(`TPU_IDX_TCTRL, 8'h04 | 8'(s));
			repeat (48 * f + 8) @(posedge clock_i);
			`CHK(per_len, 16 * f)
			`CHK(hi_len, 6 * f)
		end
		// Duty written mid-period waits for the next match
		wait_flag();
		wr(`TPU_IDX_FLAGS, 8'h01);
		rd(`TPU_IDX_FLAGS, d); `CHK(d, 8'h00)
		wr(`TPU_IDX_U1_UPPER, 8'h02);
		rd(`TPU_IDX_U1_SHADOW, d); `CHK(d, 8'h01)
		wait_flag();
		rd(`TPU_IDX_U1_SHADOW, d); `CHK(d, 8'h02)
		// Postscale bits leave the period alone
		wr(`TPU_IDX_TCTRL, 8'h7c);
		repeat (60) @(posedge clock_i);
		`CHK(per_len, 16)
		`CHK(hi_len, 10)
		// Sleep freezes the pins
		ce_i <= 1'b0;
		@(posedge clock_i);
		p = u1_pin;
		cnt = 0;
		repeat (40) begin @(posedge clock_i); if (u1_pin !== p) cnt++; end
		`CHK(cnt, 0)
		ce_i <= 1'b1;
		// Duty zero never sets, duty beyond period never clears
		wr(`TPU_IDX_U1_UPPER, 8'h00);
		wr(`TPU_IDX_U1_CTRL, 8'h0c);
		repeat (40) @(posedge clock_i);
		hi_in(48, cnt); `CHK(cnt, 0)
		wr(`TPU_IDX_U1_UPPER, 8'hff);
		repeat (40) @(posedge clock_i);
		hi_in(48, cnt); `CHK(cnt, 48)
		// Steering routes the waveform to the chosen outputs only
		wr(`TPU_IDX_DIR, 8'h00);
		wr(`TPU_IDX_STEER, 8'h06);
		repeat (2) @(posedge clock_i);
		`CHK(u1_oe, 4'h6)
		`CHK(u1_pin, 4'h6)
		// Zero control releases unit 1; unit 2 drives once enabled
		wr(`TPU_IDX_U1_CTRL, 8'h00);
		wr(`TPU_IDX_U2_UPPER, 8'h02);
		wr(`TPU_IDX_U2_CTRL, 8'h0c);
		repeat (2) @(posedge clock_i);
		`CHK(u1_oe, 4'h0)
		`CHK(u2_oe, 1'b1)
		// Unit 2 duty 8 of 16: three whole periods hold 24 high clocks
		repeat (40) @(posedge clock_i);
		cnt = 0;
		repeat (48) begin @(posedge clock_i); if (u2_pin === 1'b1) cnt++; end
		`CHK(cnt, 24)
		end_sim();
	end
endmodule
